//--- hw/drs_top.sv
// Dual rail sequencer and supervisor: orders two rails and combines their status.
// Assumes all pin inputs are asynchronous to clk; pull-ups are modelled by the pad
// ring, so an open pin arrives here as a high level.
//
// Operation
// - Enable rise starts soft-start; enable fall starts soft-stop over the ramp time.
// - Global power-good needs both rails done soft-start and no fault.
// - Power-good drops below 80 percent or on any protection fault.
// - Power-good drops whenever enable is low.
// - Global undervoltage flag is OR of per-rail input undervoltage.
// - Input undervoltage powers rails down; clears restart with new soft-start.
// - Output undervoltage flag set when any rail below 60 percent.
// - Output undervoltage after soft-start shuts rail; restart needs clear then enable rise.
// - Fault output low while any rail is 25 percent over target.
// - Overvoltage suppresses that rail's high-side pulses until it clears.
// - Current above 8.5A caps pulse width and sets overcurrent flag.
// - Current above 10A shuts rail; restart needs enable rise.
// - Delay-mode pin high selects fixed delay, low selects power-good sequencing.
// - Sequencing delay defaults to 6ms, adjustable 3ms to 16ms.
// - In fixed-delay mode soft-start lasts two thirds of the sequencing delay.
// - Sequencer stays idle until sequencer-enable goes high.
// - Open mode and order pins read high; low only when grounded.
// - Fixed-delay: remaining delay after soft-start before next rail enable.
// - Power-good mode: 4ms soft-start, power-good, then full delay, next enable.
// - Order pin high runs rail A first, low runs rail B first.
`timescale 1ns/100ps
`default_nettype none
module drs_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic seq_enable,
  input wire logic delay_mode,
  input wire logic order_select,
  input wire logic [drs_pkg::CNT_W-1:0] seq_delay_cyc,
  input wire logic rail_a_enable,
  input wire logic rail_b_enable,
  input wire logic [1:0] input_undervolt_flag,
  input wire logic [1:0] below_80,
  input wire logic [1:0] below_60,
  input wire logic [1:0] over_25,
  input wire logic [1:0] over_85a,
  input wire logic [1:0] over_10a,
  input wire logic thermal,
  output logic step_one_output,
  output logic step_two_output,
  output logic [1:0] rail_ok_step,
  output logic rails_ok,
  output logic global_undervolt,
  output logic output_undervolt_flag,
  output logic fault_out_n,
  output logic overcurrent_flag,
  output logic [1:0] overvoltage_flag,
  output logic [1:0] hs_allow,
  output logic [1:0] hs_limit,
  output logic [1:0] ramp_up,
  output logic [1:0] ramp_down
);
  import drs_pkg::*;

  // Synchronised pins: two enables, six comparator pairs, four control pins
  localparam int unsigned NSYNC = 18;

  // Reset release and pin synchronisers
  logic [1:0] rst_sync_reg;
  logic rst_ok_n;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] raw;
  // Sequencer timing and state
  logic [CNT_W-1:0] delay_cyc;
  logic [CNT_W-1:0] ramp_cyc;
  logic [CNT_W-1:0] pre_cyc;
  logic [CNT_W-1:0] wait_cyc;
  logic [CNT_W-1:0] cnt_reg;
  drs_seq_t seq_reg;
  logic first_reg;
  logic second_reg;
  logic [1:0] enable;
  logic [1:0] soft_done;
  logic [1:0] rok;
  logic first_ok;
  // Synchronised pin levels
  logic [1:0] s_en;
  logic [1:0] s_iuv;
  logic [1:0] s_b80;
  logic [1:0] s_b60;
  logic [1:0] s_o25;
  logic [1:0] s_o85;
  logic [1:0] s_o10;
  logic s_seq_en;
  logic s_mode;
  logic s_order;
  logic s_therm;
  // Global flag registers
  logic [1:0] uvo_reg;
  logic uv_out_reg;
  logic fault_n_reg;
  logic oc_reg;
  logic ok_reg;
  logic [1:0] okstep_reg;
  logic [1:0] ov_reg;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_ok_n = rst_sync_reg[1];

  // Synchroniser bit map: enables, then per-rail comparators, then control pins
  assign raw[1:0] = {rail_b_enable, rail_a_enable};
  assign raw[3:2] = input_undervolt_flag;
  assign raw[5:4] = below_80;
  assign raw[7:6] = below_60;
  assign raw[9:8] = over_25;
  assign raw[11:10] = over_85a;
  assign raw[13:12] = over_10a;
  assign raw[14] = seq_enable;
  assign raw[15] = delay_mode;
  assign raw[16] = order_select;
  assign raw[17] = thermal;
  // Two-flop synchronisers; mode and order reset high to match the pull-ups
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      s1_reg <= 18'h18000;
      s2_reg <= 18'h18000;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end
  assign s_en = s2_reg[1:0];
  assign s_iuv = s2_reg[3:2];
  assign s_b80 = s2_reg[5:4];
  assign s_b60 = s2_reg[7:6];
  assign s_o25 = s2_reg[9:8];
  assign s_o85 = s2_reg[11:10];
  assign s_o10 = s2_reg[13:12];
  assign s_seq_en = s2_reg[14];
  assign s_mode = s2_reg[15];
  assign s_order = s2_reg[16];
  assign s_therm = s2_reg[17];

  ////////////////////////////////////////////////////////////////////////
  // Delay clamped to the legal range; fixed-delay soft-start is two thirds of it
  // Out-of-range delays are clamped, never refused, so the delay wait always ends
  always_comb begin
    if (seq_delay_cyc < CNT_W'(SEQ_DELAY_MIN_CYC)) begin
      delay_cyc = CNT_W'(SEQ_DELAY_MIN_CYC);
    end else if (seq_delay_cyc > CNT_W'(SEQ_DELAY_MAX_CYC)) begin
      delay_cyc = CNT_W'(SEQ_DELAY_MAX_CYC);
    end else begin
      delay_cyc = seq_delay_cyc;
    end
  end
  // Product fits 32 bits: the largest delay times two stays below 2^22
  assign pre_cyc = CNT_W'((32'(delay_cyc) * SS_NUM) / SS_DEN);
  // Fixed-delay ramps at 2/3 of delay; power-good mode ramps at 4ms
  assign ramp_cyc = s_mode ? pre_cyc : CNT_W'(PG_SOFT_START_CYC);
  // Fixed mode waits the rest of the delay; power-good mode the full delay
  assign wait_cyc = s_mode ? (delay_cyc - pre_cyc) : delay_cyc;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: first step, first rail power-good, delay, second step
  // Power-good of whichever rail the order pin put first
  assign first_ok = s_order ? rok[0] : rok[1];
  // Delay counter is shared; only one wait runs at a time
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      seq_reg <= DRS_IDLE;
      cnt_reg <= '0;
      first_reg <= 1'b0;
      second_reg <= 1'b0;
    end else if (!s_seq_en) begin
      seq_reg <= DRS_IDLE;
      cnt_reg <= '0;
      first_reg <= 1'b0;
      second_reg <= 1'b0;
    end else begin
      unique case (seq_reg)
        DRS_IDLE: begin
          first_reg <= 1'b1;
          cnt_reg <= '0;
          seq_reg <= DRS_FIRST;
        end
        DRS_FIRST: begin
          // A rail that never reaches power-good stalls the sequence here
          if (first_ok) begin
            seq_reg <= DRS_WAIT;
          end
        end
        DRS_WAIT: begin
          if (cnt_reg >= wait_cyc - 1'b1) begin
            second_reg <= 1'b1;
            cnt_reg <= '0;
            seq_reg <= DRS_SECOND;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        DRS_SECOND: begin
          seq_reg <= DRS_DONE;
        end
        DRS_DONE: begin
          // Holds until sequencer-enable drops; a new run needs a fresh enable
          seq_reg <= DRS_DONE;
        end
      endcase
    end
  end
  // Order pin swaps which register drives which step pin
  assign step_one_output = s_order ? first_reg : second_reg;
  assign step_two_output = s_order ? second_reg : first_reg;
  // Rail enables come back from the board, so they pass the synchroniser too
  assign enable = s_en;

  ////////////////////////////////////////////////////////////////////////
  // Rails; bit 0 is rail A, bit 1 rail B
  // Input undervolt is a device-wide lockout, so every rail sees the OR
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_rail
      drs_rail u_rail (
        .clk(clk),
        .rst_n(rst_ok_n),
        .enable(enable[g]),
        .ramp_cyc(ramp_cyc),
        .in_uv(|s_iuv),
        .below_80(s_b80[g]),
        .below_60(s_b60[g]),
        .over_25(s_o25[g]),
        .over_85a(s_o85[g]),
        .over_10a(s_o10[g]),
        .thermal(s_therm),
        .soft_done(soft_done[g]),
        .rail_ok(rok[g]),
        .hs_allow(hs_allow[g]),
        .hs_limit(hs_limit[g]),
        .ramp_up(ramp_up[g]),
        .ramp_down(ramp_down[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Global power-good; registered, so a one-cycle comparator glitch still pulses it one cycle later
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      ok_reg <= 1'b0;
      okstep_reg <= 2'h0;
    end else begin
      ok_reg <= &rok && &soft_done && &s_en && s_seq_en && !(|s_iuv);
      okstep_reg <= rok;
    end
  end

  // Input and output undervoltage flags
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      uvo_reg <= 2'h0;
      uv_out_reg <= 1'b0;
    end else begin
      uvo_reg <= s_iuv;
      uv_out_reg <= |s_b60;
    end
  end

  // Overvoltage: fault output and per-rail flag follow the same comparators
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      fault_n_reg <= 1'b1;
      ov_reg <= 2'h0;
    end else begin
      fault_n_reg <= ~(|s_o25);
      ov_reg <= s_o25;
    end
  end

  // Overcurrent flag; the pulse cap itself is combinational in each rail
  always_ff @(posedge clk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      oc_reg <= 1'b0;
    end else begin
      oc_reg <= |s_o85;
    end
  end
  assign rails_ok = ok_reg;
  assign rail_ok_step = okstep_reg;
  assign global_undervolt = |uvo_reg;
  assign output_undervolt_flag = uv_out_reg;
  assign fault_out_n = fault_n_reg;
  assign overcurrent_flag = oc_reg;
  assign overvoltage_flag = ov_reg;
endmodule : drs_top
`default_nettype wire

//--- hw/drs_pkg.sv
// Shared constants for the dual rail sequencer and supervisor.
// Assumes a 100 MHz system clock; all times are converted to cycles here.
package drs_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SEQ_DELAY_MIN_MS = 3;
  localparam int unsigned SEQ_DELAY_DEF_MS = 6;
  localparam int unsigned SEQ_DELAY_MAX_MS = 16;
  localparam int unsigned PG_SOFT_START_MS = 4;
  localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
  localparam int unsigned SEQ_DELAY_DEF_CYC = SEQ_DELAY_DEF_MS * CYC_PER_MS;
  localparam int unsigned SEQ_DELAY_MIN_CYC = SEQ_DELAY_MIN_MS * CYC_PER_MS;
  localparam int unsigned SEQ_DELAY_MAX_CYC = SEQ_DELAY_MAX_MS * CYC_PER_MS;
  localparam int unsigned PG_SOFT_START_CYC = PG_SOFT_START_MS * CYC_PER_MS;
  // Soft-start is two thirds of the sequencing delay in fixed-delay mode
  localparam int unsigned SS_NUM = 2;
  localparam int unsigned SS_DEN = 3;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned RAMP_W = 2;
  // Rail ramp states
  typedef enum logic [3:0] {
    DRS_OFF  = 4'h1,
    DRS_UP   = 4'h2,
    DRS_ON   = 4'h4,
    DRS_DOWN = 4'h8
  } drs_rail_t;
  // Sequencer states
  typedef enum logic [4:0] {
    DRS_IDLE   = 5'h01,
    DRS_FIRST  = 5'h02,
    DRS_WAIT   = 5'h04,
    DRS_SECOND = 5'h08,
    DRS_DONE   = 5'h10
  } drs_seq_t;
endpackage : drs_pkg

//--- hw/drs_rail.sv
// One regulator rail: soft-start and soft-stop ramp, latched faults, power-good.
// Assumes synchronised fault and enable inputs on the same clock as this module.
`timescale 1ns/100ps
`default_nettype none
module drs_rail (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [drs_pkg::CNT_W-1:0] ramp_cyc,
  input wire logic in_uv,
  input wire logic below_80,
  input wire logic below_60,
  input wire logic over_25,
  input wire logic over_85a,
  input wire logic over_10a,
  input wire logic thermal,
  output logic soft_done,
  output logic rail_ok,
  output logic hs_allow,
  output logic hs_limit,
  output logic ramp_up,
  output logic ramp_down
);
  import drs_pkg::*;

  drs_rail_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic en_d_reg;
  logic latch_reg;
  logic en_rise;
  logic shut;

  assign en_rise = enable & ~en_d_reg;
  // Latched faults need a fresh enable edge; input undervoltage does not
  assign shut = ~enable | in_uv | latch_reg | thermal;

  ////////////////////////////////////////////////////////////////////////
  // Enable edge detect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= enable;
    end
  end

  // Output undervoltage and hard overcurrent latch until enable re-rises
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= 1'b0;
    end else if ((below_60 && state_reg == DRS_ON) || over_10a) begin
      latch_reg <= 1'b1;
    end else if (en_rise && !below_60) begin
      latch_reg <= 1'b0;
    end
  end

  // Ramp state machine; soft-stop uses the same preset ramp time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= DRS_OFF;
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        DRS_OFF: begin
          cnt_reg <= '0;
          if (enable && !shut) begin
            state_reg <= DRS_UP;
          end
        end
        DRS_UP: begin
          if (shut) begin
            state_reg <= DRS_DOWN;
            cnt_reg <= '0;
          end else if (cnt_reg >= ramp_cyc - 1'b1) begin
            state_reg <= DRS_ON;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        DRS_ON: begin
          cnt_reg <= '0;
          if (shut) begin
            state_reg <= DRS_DOWN;
          end
        end
        DRS_DOWN: begin
          // A cleared cause restarts at once with a fresh soft-start from zero
          if (!shut) begin
            state_reg <= DRS_UP;
            cnt_reg <= '0;
          end else if (cnt_reg >= ramp_cyc - 1'b1) begin
            state_reg <= DRS_OFF;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // Status and switch gating
  assign soft_done = (state_reg == DRS_ON);
  assign rail_ok = soft_done && !shut && !below_80 && !over_10a && !over_25;
  assign hs_allow = (state_reg == DRS_UP || state_reg == DRS_ON) && !over_25;
  assign hs_limit = over_85a;
  assign ramp_up = (state_reg == DRS_UP);
  assign ramp_down = (state_reg == DRS_DOWN);
endmodule : drs_rail
`default_nettype wire

//--- sim/drs_top_asserts.sv
// Checker for the dual rail sequencer top: supervisory flags, steps and ramps.
// Assumes pin inputs pass a two-flop synchroniser and one flag register.
`timescale 1ns/100ps
`default_nettype none
module drs_top_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic seq_enable,
  input wire logic rail_a_enable,
  input wire logic [1:0] input_undervolt_flag,
  input wire logic [1:0] below_60,
  input wire logic [1:0] over_25,
  input wire logic [1:0] over_85a,
  input wire logic [1:0] over_10a,
  input wire logic thermal,
  input wire logic step_one_output,
  input wire logic step_two_output,
  input wire logic rails_ok,
  input wire logic global_undervolt,
  input wire logic output_undervolt_flag,
  input wire logic fault_out_n,
  input wire logic overcurrent_flag,
  input wire logic [1:0] ramp_up
);
  logic [3:0] up_reg;
  logic ok;
  // Internal reset trails rst_n by two flops, so checks wait until it has settled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_reg <= 4'h0;
    end else if (up_reg != 4'h8) begin
      up_reg <= up_reg + 4'h1;
    end
  end
  assign ok = (up_reg == 4'h8);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  property p_uv_set; ok && $rose(|input_undervolt_flag) |-> ##[1:4] global_undervolt; endproperty
  a_uv_set: assert property (p_uv_set) else $error("undervolt flag late");
  property p_uv_clr; ok && $fell(|input_undervolt_flag) |-> ##[1:4] !global_undervolt; endproperty
  a_uv_clr: assert property (p_uv_clr) else $error("undervolt flag stuck");
  property p_ouv; ok && $rose(|below_60) |-> ##[1:4] output_undervolt_flag; endproperty
  a_ouv: assert property (p_ouv) else $error("output undervolt flag late");
  property p_flt; ok && $rose(|over_25) |-> ##[1:4] !fault_out_n; endproperty
  a_flt: assert property (p_flt) else $error("fault output not driven");
  property p_flt_rel; ok && $fell(|over_25) |-> ##[1:4] fault_out_n; endproperty
  a_flt_rel: assert property (p_flt_rel) else $error("fault output not released");
  property p_oc; ok && $rose(|over_85a) |-> ##[1:4] overcurrent_flag; endproperty
  a_oc: assert property (p_oc) else $error("overcurrent flag late");
  property p_pg_en; ok && $fell(rail_a_enable) |-> ##[1:4] !rails_ok; endproperty
  a_pg_en: assert property (p_pg_en) else $error("power good kept with enable low");
  property p_dis; (ok && !seq_enable) [*5] |-> !step_one_output && !step_two_output; endproperty
  a_dis: assert property (p_dis) else $error("step active while disabled");
  property p_ramp;
    ok && $rose(rail_a_enable) && !(|input_undervolt_flag) && !(|below_60) && !(|over_10a)
      && !thermal |-> ##[1:5] ramp_up[0];
  endproperty
  a_ramp: assert property (p_ramp) else $error("soft start not begun");
  // Main scenarios reached
  c_uv: cover property (ok && global_undervolt);
  c_flt: cover property (ok && !fault_out_n);
  c_step: cover property (ok && step_one_output);
endmodule : drs_top_asserts
bind drs_top drs_top_asserts u_chk (.clk(clk), .rst_n(rst_n), .seq_enable(seq_enable),
  .rail_a_enable(rail_a_enable), .input_undervolt_flag(input_undervolt_flag),
  .below_60(below_60), .over_25(over_25), .over_85a(over_85a), .over_10a(over_10a),
  .thermal(thermal),
  .step_one_output(step_one_output), .step_two_output(step_two_output),
  .rails_ok(rails_ok), .global_undervolt(global_undervolt),
  .output_undervolt_flag(output_undervolt_flag), .fault_out_n(fault_out_n),
  .overcurrent_flag(overcurrent_flag), .ramp_up(ramp_up));
`default_nettype wire

//--- sim/drs_board.sv
// Board model: loops the sequencer steps back to the two rail enables.
// Assumes the testbench drives the analog comparator levels itself.
`timescale 1ns/100ps
`default_nettype none
module drs_board (
  input wire logic step_one_output,
  input wire logic step_two_output,
  input wire logic cut,
  output logic rail_a_enable,
  output logic rail_b_enable
);
  ////////////////////////////////////////////////////////////////////////////////
  // Step one feeds rail A, step two rail B; cut models a pulled enable jumper
  assign rail_a_enable = step_one_output & ~cut;
  assign rail_b_enable = step_two_output & ~cut;
endmodule : drs_board
`default_nettype wire

//--- sim/dual_rail_sequencer_supervisor_tb.sv
// Testbench for the dual rail sequencer top with the board loop-back model.
// Assumes the design flags answer within four cycles of a pin change.
`timescale 1ns/100ps
`default_nettype none
module dual_rail_sequencer_supervisor_tb;
  import drs_pkg::*;
  logic clk, rst_n, seq_enable, delay_mode, order_select, thermal, cut;
  logic [CNT_W-1:0] seq_delay_cyc;
  logic [1:0] iuv, b80, b60, o25, o85, o10, pg_step, ovf, hsa, hsl, rup, rdn;
  logic rail_a_enable, rail_b_enable, s1, s2, rails_ok, guv, ouv, flt_n, oc;
  int miscompares, checks_done;
  drs_top dut (.clk(clk), .rst_n(rst_n), .seq_enable(seq_enable), .delay_mode(delay_mode),
    .order_select(order_select), .seq_delay_cyc(seq_delay_cyc),
    .rail_a_enable(rail_a_enable), .rail_b_enable(rail_b_enable),
    .input_undervolt_flag(iuv), .below_80(b80), .below_60(b60), .over_25(o25),
    .over_85a(o85), .over_10a(o10), .thermal(thermal), .step_one_output(s1),
    .step_two_output(s2), .rail_ok_step(pg_step), .rails_ok(rails_ok),
    .global_undervolt(guv), .output_undervolt_flag(ouv), .fault_out_n(flt_n),
    .overcurrent_flag(oc), .overvoltage_flag(ovf), .hs_allow(hsa), .hs_limit(hsl),
    .ramp_up(rup), .ramp_down(rdn));
  drs_board board (.step_one_output(s1), .step_two_output(s2), .cut(cut),
    .rail_a_enable(rail_a_enable), .rail_b_enable(rail_b_enable));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Inputs move 1 ns after the edge so the design never samples them mid-change
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Supervisory word {undervolt, output undervolt, fault_n, overcurrent}
  function automatic logic [3:0] exp_sup();
    return {|iuv, |b60, ~|o25, |o85};
  endfunction : exp_sup
  task automatic conclude();
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // Watchdog: the sequence needs about 250 cycles, so 3000 means a hang
  initial begin
    #(3000 * 10);
    miscompares++;
    conclude();
  end
  initial begin
    miscompares = 0;
    checks_done = 0;
    rst_n = 1'b0;
    seq_enable = 1'b0;
    delay_mode = 1'b1;
    order_select = 1'b1;
    thermal = 1'b0;
    cut = 1'b0;
    seq_delay_cyc = 24'(SEQ_DELAY_DEF_CYC);
    {iuv, b80, b60, o25, o85, o10} = 12'h000;
    void'($urandom(32'h0393));
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    tick(1);
    cmp({s1, s2, rails_ok, flt_n}, 4'h1);
    tick(4);
    // Flag sweep: the first four patterns hit each bit and both, the rest random
    for (int i = 0; i < 24; i++) begin
      if (i < 4) {iuv, b60, o25, o85, o10, b80} = {6{2'(i)}};
      else {iuv, b60, o25, o85, o10, b80} = 12'($urandom);
      tick(5);
      cmp({guv, ouv, flt_n, oc}, exp_sup());
      cmp({2'h0, ovf}, {2'h0, o25});
      cmp({2'h0, hsl}, {2'h0, o85});
    end
    {iuv, b80, b60, o25, o85, o10} = 12'h000;
    tick(5);
    seq_enable = 1'b1;
    for (int k = 0; k < 10 && s1 !== 1'b1; k++) tick(1);
    cmp({2'h0, s1, s2}, 4'h2);
    tick(6);
    cmp({2'h0, rup}, 4'h1);
    cmp({rails_ok, 1'b0, pg_step}, 4'h0);
    o25 = 2'h1;
    tick(5);
    cmp(4'(hsa[0]), 4'h0);
    o25 = 2'h0;
    o85 = 2'h1;
    tick(5);
    cmp({2'h0, hsa[0], hsl[0]}, 4'h3);
    o85 = 2'h0;
    // Input undervolt drops the rail, then restarts it on its own
    iuv = 2'h2;
    tick(5);
    cmp({1'b0, rup[0], rdn[0], rails_ok}, 4'h2);
    iuv = 2'h0;
    tick(6);
    cmp(4'(rup[0]), 4'h1);
    // Below 60 percent during soft-start is the ramp itself: flag only, no latch
    b60 = 2'h1;
    tick(5);
    cmp({2'h0, ouv, rup[0]}, 4'h3);
    b60 = 2'h0;
    // Hard overcurrent latches the rail off until the enable is cycled
    o10 = 2'h1;
    tick(5);
    o10 = 2'h0;
    tick(6);
    cmp({2'h0, rup[0], rails_ok}, 4'h0);
    cut = 1'b1;
    tick(5);
    cmp({2'h0, rdn[0], rails_ok}, 4'h2);
    cut = 1'b0;
    tick(6);
    cmp(4'(rup[0]), 4'h1);
    seq_enable = 1'b0;
    tick(6);
    cmp({2'h0, s1, s2}, 4'h0);
    // Power-good mode with reversed order: step two and rail B go first
    delay_mode = 1'b0;
    order_select = 1'b0;
    tick(4);
    seq_enable = 1'b1;
    for (int k = 0; k < 10 && s2 !== 1'b1; k++) tick(1);
    cmp({2'h0, s1, s2}, 4'h1);
    tick(6);
    cmp({2'h0, rup}, 4'h2);
    conclude();
  end
endmodule : dual_rail_sequencer_supervisor_tb
`default_nettype wire
